// ===== rtl/svw_pkg.sv
package svw_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int IRQ_RELEASE_MIN_TIME_NS = 1000;
  localparam int IRQ_RELEASE_CYC = (IRQ_RELEASE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IFACE_SWITCH_MAX_US = 8;
  localparam int IFACE_SWITCH_CYC = IFACE_SWITCH_MAX_US * (CLK_HZ / 1_000_000);
  localparam int RST_PULSE_US = 10;
  localparam int RST_PULSE_CYC = RST_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int WD_BASE_PERIOD_MS = 1;
  localparam int WD_BASE_CYC_DEF = WD_BASE_PERIOD_MS * (CLK_HZ / 1000);
  localparam int STARTUP_SERVICE_TIMEOUT_MS = 64;
  localparam int STARTUP_TO_CYC_DEF = STARTUP_SERVICE_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int STARTUP_MAX_FAILS = 3;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int ADDR_DONE_BIT = 5;
  localparam int RW_POS = 7;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_TRIG = 5'h01;
  localparam logic [4:0] ADDR_IRQ_TOP = 5'h02;
  localparam logic [4:0] ADDR_SRC_SUPPLY = 5'h03;
  localparam logic [4:0] ADDR_SRC_BUS = 5'h04;
  localparam logic [4:0] ADDR_SRC_TEMP = 5'h05;
  localparam logic [4:0] ADDR_RST_REASON = 5'h06;
  localparam logic [4:0] ADDR_STATUS = 5'h07;
  localparam int NUM_REGIONS = 3;
  localparam logic [2:0] PSEL_RESET = 3'h0;

  localparam int REASON_STARTUP = 0;
  localparam int REASON_EARLY = 1;
  localparam int REASON_LATE = 2;
  localparam int REASON_TIMEOUT = 3;

  typedef enum logic [1:0] {WD_STARTUP, WD_WINDOW, WD_TIMEOUT, WD_HALT} svw_wd_mode_t;

endpackage : svw_pkg

// ===== rtl/svw_supervisor.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Two-stage synchroniser
// ============================================================================
module svw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : svw_sync

// ============================================================================
// Serial link engine, clocked by the host serial clock
// ============================================================================
module svw_spi_link
  import svw_pkg::*;
(
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic [7:0] rd_data_i,
  output logic wr_tgl_o,
  output logic [4:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic rd_tgl_o,
  output logic [4:0] rd_addr_o
);
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] hdr;
    logic [7:0] dat;
  } svw_frame_t;

  typedef struct packed {
    logic wr_tgl;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_tgl;
    logic [4:0] rd_addr;
  } svw_hold_t;

  typedef struct packed {
    logic armed;
    logic oe;
    logic [7:0] sh;
  } svw_out_t;

  svw_frame_t f_q, f_d;
  svw_hold_t h_q, h_d;
  svw_out_t o_q, o_d;
  logic pol_q;
  logic samp_clk;

  // The clock level is caught on the select fall itself, before any serial edge exists.
  always_ff @(negedge cs_n_i or posedge rst_i)
  begin
    if (rst_i)
      pol_q <= 1'b1;
    else
      pol_q <= sclk_i;
  end

  // Sampling edge is the rising edge of this clock for both polarities.
  assign samp_clk = ~(sclk_i ^ pol_q);

  always_comb
  begin
    f_d = f_q;
    h_d = h_q;
    o_d = o_q;
    // A polarity change gives a false sampling edge at the select fall, so bits count only after a shift edge.
    o_d.armed = 1'b1;
    if (o_q.armed && f_q.cnt < 5'(FRAME_BITS))
    begin
      f_d.cnt = f_q.cnt + 5'h01;
      if (f_q.cnt < 5'(HDR_BITS))
        f_d.hdr = {f_q.hdr[6:0], sdi_i};
      else
        f_d.dat = {f_q.dat[6:0], sdi_i};
    end
    if (f_q.cnt == 5'(ADDR_DONE_BIT) && f_q.hdr[4])
    begin
      h_d.rd_addr = {f_q.hdr[3:0], sdi_i};
      h_d.rd_tgl = ~h_q.rd_tgl;
    end
    if (f_q.cnt == 5'(FRAME_BITS - 1) && !f_q.hdr[RW_POS])
    begin
      h_d.wr_addr = f_q.hdr[6:2];
      h_d.wr_data = {f_q.dat[6:0], sdi_i};
      h_d.wr_tgl = ~h_q.wr_tgl;
    end
    if (f_q.cnt == 5'(HDR_BITS) && f_q.hdr[RW_POS])
    begin
      o_d.sh = rd_data_i;
      o_d.oe = 1'b1;
    end
    else if (o_q.oe)
      o_d.sh = {o_q.sh[6:0], 1'b0};
  end

  // Select high clears the frame, so a short write never reaches the toggle.
  always_ff @(posedge samp_clk or posedge cs_n_i)
  begin
    if (cs_n_i)
      f_q <= '0;
    else
      f_q <= f_d;
  end

  // Handover words survive the select rise so the core can collect them.
  always_ff @(posedge samp_clk or posedge rst_i)
  begin
    if (rst_i)
      h_q <= '0;
    else
      h_q <= h_d;
  end

  always_ff @(negedge samp_clk or posedge cs_n_i)
  begin
    if (cs_n_i)
      o_q <= '0;
    else
      o_q <= o_d;
  end

  assign sdo_o = o_q.sh[7];
  assign sdo_oe_o = o_q.oe;
  assign wr_tgl_o = h_q.wr_tgl;
  assign wr_addr_o = h_q.wr_addr;
  assign wr_data_o = h_q.wr_data;
  assign rd_tgl_o = h_q.rd_tgl;
  assign rd_addr_o = h_q.rd_addr;
endmodule : svw_spi_link

// ============================================================================
// Supervisor top
// ============================================================================
module svw_supervisor
  import svw_pkg::*;
#(
  parameter int WD_BASE_CYC = WD_BASE_CYC_DEF,
  parameter int STARTUP_TO_CYC = STARTUP_TO_CYC_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  input wire logic iface_strap_i,
  input wire logic first_regulator_uv_i,
  input wire logic normal_mode_i,
  input wire logic standby_mode_i,
  input wire logic [23:0] irq_event_i,
  output logic irq_out_n_o,
  output logic rst_out_n_o,
  output logic iface_i2c_o,
  output logic sleep_o
);
  typedef struct packed {
    svw_wd_mode_t mode;
    logic [23:0] cnt;
    logic [1:0] fails;
    logic sleep;
    logic [2:0] psel;
    logic [8:0] rst_cnt;
    logic rst_n;
    logic [NUM_REGIONS-1:0][7:0] src;
    logic [3:0] reason;
    logic [5:0] rel_cnt;
    logic irq_n;
    logic [7:0] rd_data;
    logic wr_seen;
    logic rd_seen;
    logic normal_prev;
    logic standby_prev;
    logic iface_i2c;
    logic [8:0] sw_cnt;
  } svw_core_t;

  svw_core_t q, d;
  logic wr_tgl, rd_tgl;
  logic [4:0] wr_addr, rd_addr;
  logic [7:0] wr_data;
  logic [3:0] sync_q;
  logic uv_s, strap_s, wr_tgl_s, rd_tgl_s;
  logic wr_ev, rd_ev, trig, fault;
  logic [23:0] period_c;
  logic [3:0] cause;
  logic [7:0] clr_mask;

  svw_spi_link u_link (
    .rst_i(rst_i),
    .cs_n_i(spi_cs_n_i),
    .sclk_i(spi_sclk_i),
    .sdi_i(spi_sdi_i),
    .sdo_o(spi_sdo_o),
    .sdo_oe_o(spi_sdo_oe_o),
    .rd_data_i(q.rd_data),
    .wr_tgl_o(wr_tgl),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .rd_tgl_o(rd_tgl),
    .rd_addr_o(rd_addr)
  );

  svw_sync #(.WIDTH(4)) u_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i({first_regulator_uv_i, iface_strap_i, wr_tgl, rd_tgl}),
    .q_o(sync_q)
  );

  assign {uv_s, strap_s, wr_tgl_s, rd_tgl_s} = sync_q;

  always_comb
  begin
    d = q;
    cause = 4'h0;
    fault = 1'b0;
    clr_mask = 8'h00;
    // The address words are stable long before the toggle is seen here.
    wr_ev = (wr_tgl_s != q.wr_seen) && !q.iface_i2c;
    rd_ev = (rd_tgl_s != q.rd_seen) && !q.iface_i2c;
    d.wr_seen = wr_tgl_s;
    d.rd_seen = rd_tgl_s;
    trig = wr_ev && (wr_addr == ADDR_TRIG);
    period_c = 24'(WD_BASE_CYC * (int'(q.psel) + 1));

    // ========================================================================
    // Interface selection
    // ========================================================================
    if (strap_s != q.iface_i2c)
    begin
      d.sw_cnt = q.sw_cnt + 9'h001;
      if (q.sw_cnt == 9'(IFACE_SWITCH_CYC - 1))
      begin
        d.iface_i2c = strap_s;
        d.sw_cnt = 9'h000;
      end
    end
    else
      d.sw_cnt = 9'h000;

    // ========================================================================
    // Period programming
    // ========================================================================
    if (wr_ev && wr_addr == ADDR_CTRL)
    begin
      if (q.mode != WD_WINDOW || q.cnt >= (period_c >> 1))
        d.psel = wr_data[2:0];
    end

    // ========================================================================
    // Watchdog
    // ========================================================================
    if (!q.rst_n)
    begin
      d.cnt = 24'h000000;
      d.rst_cnt = q.rst_cnt - 9'h001;
      if (q.rst_cnt == 9'h001)
        d.rst_n = 1'b1;
    end
    else if (uv_s)
      d.cnt = 24'h000000;
    else
    begin
      d.cnt = q.cnt + 24'h000001;
      case (q.mode)
        WD_STARTUP:
        begin
          if (trig)
          begin
            d.mode = normal_mode_i ? WD_WINDOW : WD_TIMEOUT;
            d.cnt = 24'h000000;
            d.fails = 2'h0;
          end
          else if (q.cnt >= 24'(STARTUP_TO_CYC - 1))
          begin
            fault = 1'b1;
            cause[REASON_STARTUP] = 1'b1;
            d.fails = q.fails + 2'h1;
            if (q.fails == 2'(STARTUP_MAX_FAILS - 1))
              d.sleep = 1'b1;
          end
        end
        WD_WINDOW:
        begin
          if (trig && q.cnt < (period_c >> 1))
          begin
            fault = 1'b1;
            cause[REASON_EARLY] = 1'b1;
          end
          else if (trig)
            d.cnt = 24'h000000;
          else if (q.cnt >= period_c - 24'h000001)
          begin
            fault = 1'b1;
            cause[REASON_LATE] = 1'b1;
          end
        end
        WD_TIMEOUT:
        begin
          if (trig)
            d.cnt = 24'h000000;
          else if (q.cnt >= period_c - 24'h000001)
          begin
            fault = 1'b1;
            cause[REASON_TIMEOUT] = 1'b1;
          end
        end
        WD_HALT:
          d.cnt = 24'h000000;
        default:
          d.mode = WD_STARTUP;
      endcase
      if (fault)
      begin
        d.rst_n = 1'b0;
        d.rst_cnt = 9'(RST_PULSE_CYC);
        d.cnt = 24'h000000;
        d.mode = d.sleep ? WD_HALT : WD_STARTUP;
      end
    end
    // Mode entries are taken under undervoltage too, otherwise an entry during a dip would be lost.
    if (q.rst_n && q.mode != WD_HALT && !fault)
    begin
      if (normal_mode_i && !q.normal_prev)
      begin
        d.mode = WD_WINDOW;
        d.cnt = 24'h000000;
      end
      else if (standby_mode_i && !q.standby_prev)
      begin
        d.mode = WD_TIMEOUT;
        d.cnt = 24'h000000;
      end
    end
    d.normal_prev = normal_mode_i;
    d.standby_prev = standby_mode_i;

    // ========================================================================
    // Reads and the reset-reason register
    // ========================================================================
    if (rd_ev)
    begin
      case (rd_addr)
        ADDR_CTRL: d.rd_data = {5'h00, q.psel};
        ADDR_IRQ_TOP: d.rd_data = {5'h00, |q.src[2], |q.src[1], |q.src[0]};
        ADDR_SRC_SUPPLY: d.rd_data = q.src[0];
        ADDR_SRC_BUS: d.rd_data = q.src[1];
        ADDR_SRC_TEMP: d.rd_data = q.src[2];
        ADDR_RST_REASON: d.rd_data = {4'h0, q.reason};
        ADDR_STATUS: d.rd_data = {3'h0, q.iface_i2c, q.sleep, q.rst_n, 2'(q.mode)};
        default: d.rd_data = 8'h00;
      endcase
    end
    // A cause that lands in the clearing cycle is kept.
    if (rd_ev && rd_addr == ADDR_RST_REASON)
      d.reason = cause;
    else
      d.reason = q.reason | cause;

    // ========================================================================
    // Interrupt sources and output
    // ========================================================================
    for (int r = 0; r < NUM_REGIONS; r++)
    begin
      if (wr_ev && wr_addr == ADDR_SRC_SUPPLY + 5'(r))
        clr_mask = wr_data & q.src[r];
      d.src[r] = (q.src[r] & ~((wr_ev && wr_addr == ADDR_SRC_SUPPLY + 5'(r)) ? wr_data : 8'h00))
                 | irq_event_i[r*8 +: 8];
    end
    if (!q.rst_n)
      d.src = '0;
    if (|clr_mask)
    begin
      d.rel_cnt = 6'(IRQ_RELEASE_CYC);
      d.irq_n = 1'b1;
    end
    else if (q.rel_cnt != 6'h00)
    begin
      d.rel_cnt = q.rel_cnt - 6'h01;
      d.irq_n = 1'b1;
    end
    else
      d.irq_n = ~|d.src;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.mode <= WD_STARTUP;
      q.psel <= PSEL_RESET;
      q.rst_n <= 1'b1;
      q.irq_n <= 1'b1;
    end
    else
      q <= d;
  end

  assign irq_out_n_o = q.irq_n;
  assign rst_out_n_o = q.rst_n;
  assign iface_i2c_o = q.iface_i2c;
  assign sleep_o = q.sleep;
endmodule : svw_supervisor

`default_nettype wire

// ===== bench/svw_supervisor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module svw_supervisor_asserts
  import svw_pkg::*;
#(
  parameter int WD_BASE_CYC = WD_BASE_CYC_DEF,
  parameter int STARTUP_TO_CYC = STARTUP_TO_CYC_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_o,
  input wire logic iface_strap_i,
  input wire logic first_regulator_uv_i,
  input wire logic normal_mode_i,
  input wire logic standby_mode_i,
  input wire logic [23:0] irq_event_i,
  input wire logic irq_out_n_o,
  input wire logic rst_out_n_o,
  input wire logic iface_i2c_o,
  input wire logic sleep_o
);
  localparam int SW_MAX = 330;
  logic [8:0] lo_q;
  logic [7:0] hi_q;
  logic [2:0] uv_q;
  // ==========================================================================
  // Helper counters
  // ==========================================================================
  // Counts, saturating for the interrupt-high and undervoltage spans, keep long spans cheap instead of unrolled repetitions.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      lo_q <= 9'h000;
      hi_q <= 8'hff;
      uv_q <= 3'h0;
    end
    else
    begin
      lo_q <= rst_out_n_o ? 9'h000 : lo_q + 9'h001;
      hi_q <= !irq_out_n_o ? 8'h00 : ((hi_q == 8'hff) ? hi_q : hi_q + 8'h01);
      uv_q <= !first_regulator_uv_i ? 3'h0 : ((uv_q == 3'h7) ? uv_q : uv_q + 3'h1);
    end
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  rst_pulse_len_a: assert property ($rose(rst_out_n_o) |-> lo_q == RST_PULSE_CYC)
    else $error("reset pulse length wrong");
  irq_rst_clear_a: assert property (!rst_out_n_o ##1 !rst_out_n_o |-> irq_out_n_o)
    else $error("interrupt pending during reset");
  irq_release_a: assert property ($fell(irq_out_n_o) |-> hi_q >= IRQ_RELEASE_CYC)
    else $error("interrupt release too short");
  irq_on_event_a: assert property ((irq_event_i != 24'h000000) && rst_out_n_o &&
    (hi_q == 8'h00 || hi_q >= 8'h32) |-> ##[1:2] !irq_out_n_o) else $error("interrupt not raised");
  sleep_sticky_a: assert property (sleep_o |=> sleep_o)
    else $error("sleep dropped");
  sdo_idle_a: assert property (spi_cs_n_i ##1 spi_cs_n_i |-> !spi_sdo_oe_o && !spi_sdo_o)
    else $error("data out driven while deselected");
  strap_high_a: assert property ($rose(iface_strap_i) |-> ##[1:SW_MAX] iface_i2c_o)
    else $error("two-wire select late");
  strap_low_a: assert property ($fell(iface_strap_i) |-> ##[1:SW_MAX] !iface_i2c_o)
    else $error("four-wire select late");
  uv_hold_a: assert property ($fell(rst_out_n_o) |-> uv_q < 3'h4)
    else $error("watchdog fault under undervoltage");
endmodule : svw_supervisor_asserts

bind svw_supervisor svw_supervisor_asserts #(.WD_BASE_CYC(WD_BASE_CYC), .STARTUP_TO_CYC(STARTUP_TO_CYC)) u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i),
  .spi_sdi_i(spi_sdi_i), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o), .iface_strap_i(iface_strap_i),
  .first_regulator_uv_i(first_regulator_uv_i), .normal_mode_i(normal_mode_i), .standby_mode_i(standby_mode_i),
  .irq_event_i(irq_event_i), .irq_out_n_o(irq_out_n_o), .rst_out_n_o(rst_out_n_o), .iface_i2c_o(iface_i2c_o),
  .sleep_o(sleep_o));
`default_nettype wire

// ===== bench/svw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module svw_host_model (
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  // ==========================================================================
  // Frame driver
  // ==========================================================================
  // The deferred assignment gives the link's select-driven reset a real rising edge at start.
  initial
  begin
    cs_n_o <= 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // Serial clock stands still at the idle level outside frames.
  task automatic xfer(input logic rw, input logic [4:0] a, input logic [7:0] d, input logic pol,
                      input int nb, output logic [7:0] q);
    logic [15:0] fr;
    fr = {rw, a, 2'b00, d};
    q = 'x;
    sclk_o = pol;
    #100 cs_n_o = 1'b0;
    for (int i = 15; i >= 16 - nb; i--)
    begin
      #20 sdi_o = fr[i];
      #20 sclk_o = ~pol;
      #40;
      if (i < 8)
        q[i] = sdo_oe_i ? sdo_i : 1'bx;
      sclk_o = pol;
    end
    #40 cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #200;
  endtask : xfer
endmodule : svw_host_model
`default_nettype wire

// ===== bench/svw_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module svw_supervisor_tb
  import svw_pkg::*;
();
  logic clk;
  logic rst = 1'b0;
  logic cs_n, sclk, sdi, sdo, sdo_oe, irq_n, rst_n, i2c, sleep;
  logic strap = 1'b0;
  logic uv = 1'b1;
  logic normal = 1'b0;
  logic standby = 1'b0;
  logic [23:0] ev = 24'h000000;
  logic [7:0] rdv;
  int n_errors = 0;
  int checked = 0;
  svw_supervisor #(.WD_BASE_CYC(40), .STARTUP_TO_CYC(400)) dut (.core_clk_i(clk), .rst_i(rst),
    .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
    .iface_strap_i(strap), .first_regulator_uv_i(uv), .normal_mode_i(normal), .standby_mode_i(standby),
    .irq_event_i(ev), .irq_out_n_o(irq_n), .rst_out_n_o(rst_n), .iface_i2c_o(i2c), .sleep_o(sleep));
  svw_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", w, exp, seen);
      n_errors++;
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic pol = 1'b0, input int nb = 16);
    host.xfer(1'b0, a, d, pol, nb, rdv);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic pol = 1'b0);
    host.xfer(1'b1, a, 8'h00, pol, 16, rdv);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic pulse(input int b);
    @(posedge clk) ev <= 24'h000001 << b;
    @(posedge clk) ev <= 24'h000000;
  endtask : pulse
  // A wait that runs out is a mismatch and ends the run at once.
  task automatic waitf(input string w, input int s, input logic lvl, input int bound);
    logic v;
    for (int n = 0; n <= bound; n++)
    begin
      @(posedge clk);
      #1 v = (s == 0) ? rst_n : ((s == 1) ? i2c : sleep);
      if (v === lvl)
        return;
    end
    check(w, 8'h01, 8'h00);
    tally_and_finish();
  endtask : waitf
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_setup();
    check("reset outs", {4'h0, irq_n, rst_n, i2c, sleep}, 8'h0c);
    rd(ADDR_STATUS);
    check("status", rdv, 8'h04);
    wr(ADDR_CTRL, 8'h03, 1'b0, 12);
    rd(ADDR_CTRL, 1'b1);
    check("ctrl abort", rdv, 8'h00);
    wr(ADDR_CTRL, 8'h07, 1'b1);
    rd(ADDR_CTRL);
    check("ctrl", rdv, 8'h07);
    rd(5'h1f);
    check("unmapped", rdv, 8'h00);
    cyc(200);
    check("uv hold", 8'(rst_n), 8'h01);
    $display("setup done");
  endtask : t_setup
  task automatic t_window();
    @(posedge clk) uv <= 1'b0;
    @(posedge clk) normal <= 1'b1;
    cyc(150);
    wr(ADDR_TRIG, 8'h00);
    cyc(140);
    wr(ADDR_TRIG, 8'h00);
    check("served", 8'(rst_n), 8'h01);
    wr(ADDR_TRIG, 8'h00);
    waitf("early", 0, 1'b0, 100);
    waitf("pulse end", 0, 1'b1, 500);
    rd(ADDR_RST_REASON);
    check("why early", rdv, 8'h02);
    rd(ADDR_RST_REASON);
    check("why cleared", rdv, 8'h00);
    rd(ADDR_STATUS, 1'b1);
    check("start-up", rdv, 8'h04);
    wr(ADDR_TRIG, 8'h00);
    waitf("late", 0, 1'b0, 400);
    waitf("pulse end", 0, 1'b1, 500);
    rd(ADDR_RST_REASON);
    check("why late", rdv, 8'h04);
    $display("window done");
  endtask : t_window
  task automatic t_timeout();
    @(posedge clk) normal <= 1'b0;
    standby <= 1'b1;
    rd(ADDR_STATUS);
    check("timeout mode", rdv, 8'h06);
    waitf("timeout", 0, 1'b0, 400);
    waitf("pulse end", 0, 1'b1, 500);
    rd(ADDR_RST_REASON);
    check("why timeout", rdv, 8'h08);
    @(posedge clk) uv <= 1'b1;
    $display("timeout done");
  endtask : t_timeout
  task automatic t_strap();
    @(posedge clk) strap <= 1'b1;
    waitf("two-wire", 1, 1'b1, 340);
    wr(ADDR_CTRL, 8'h02);
    @(posedge clk) strap <= 1'b0;
    waitf("four-wire", 1, 1'b0, 340);
    rd(ADDR_CTRL);
    check("ctrl kept", rdv, 8'h07);
    $display("strap done");
  endtask : t_strap
  task automatic t_irq();
    pulse(9);
    cyc(3);
    check("irq low", 8'(irq_n), 8'h00);
    rd(ADDR_IRQ_TOP);
    check("top", rdv, 8'h02);
    rd(ADDR_SRC_BUS);
    check("bus src", rdv, 8'h02);
    wr(ADDR_SRC_BUS, 8'h00);
    rd(ADDR_SRC_BUS);
    check("zero write", rdv, 8'h02);
    fork
      wr(ADDR_SRC_BUS, 8'h02);
      begin
        cyc(20);
        pulse(8);
      end
    join
    check("released", 8'(irq_n), 8'h01);
    cyc(50);
    check("low again", 8'(irq_n), 8'h00);
    rd(ADDR_SRC_BUS);
    check("kept", rdv, 8'h01);
    wr(ADDR_SRC_BUS, 8'h01);
    rd(ADDR_IRQ_TOP);
    check("top clear", rdv, 8'h00);
    check("irq high", 8'(irq_n), 8'h01);
    pulse(17);
    $display("irq done");
  endtask : t_irq
  task automatic t_sleep();
    @(posedge clk) uv <= 1'b0;
    waitf("start-up miss", 0, 1'b0, 500);
    cyc(3);
    check("irq reset", 8'(irq_n), 8'h01);
    waitf("pulse end", 0, 1'b1, 500);
    rd(ADDR_IRQ_TOP);
    check("top reset", rdv, 8'h00);
    rd(ADDR_RST_REASON);
    check("why start-up", rdv, 8'h01);
    check("awake", 8'(sleep), 8'h00);
    waitf("sleep", 2, 1'b1, 2000);
    $display("sleep done");
  endtask : t_sleep
  // Reset rises by a deferred assignment so the link's asynchronous reset sees an edge.
  initial
  begin
    rst <= 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(5);
    t_setup();
    t_window();
    t_timeout();
    t_strap();
    t_irq();
    t_sleep();
    tally_and_finish();
  end
endmodule : svw_supervisor_tb
`default_nettype wire
